/* core/dacc_pkg.sv */
package dacc_pkg;
    localparam int NUM_CH = 2;
    localparam int DATA_W = 8;

    // printed offsets are register indices; byte address is four times each
    localparam logic [19:0] IDX_CODE_CH0 = 20'hFFF9C;
    localparam logic [19:0] IDX_CODE_CH1 = 20'hFFF9D;
    localparam logic [19:0] IDX_CTRL = 20'hFFF9E;
    localparam logic [19:0] IDX_STBY = 20'hEE01A;
    localparam logic [31:0] ADDR_CODE_CH0 = {10'h000, IDX_CODE_CH0, 2'h0};
    localparam logic [31:0] ADDR_CODE_CH1 = {10'h000, IDX_CODE_CH1, 2'h0};
    localparam logic [31:0] ADDR_CTRL = {10'h000, IDX_CTRL, 2'h0};
    localparam logic [31:0] ADDR_STBY = {10'h000, IDX_STBY, 2'h0};

    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h1F;
    localparam logic [7:0] STBY_RESET = 8'hFE;
    localparam logic [7:0] CTRL_RSVD_MASK = 8'h1F;
    localparam logic [7:0] STBY_RSVD_MASK = 8'hFE;
    localparam int CTRL_OE1_BIT = 7;
    localparam int CTRL_OE0_BIT = 6;
    localparam int CTRL_JOINT_BIT = 5;
    localparam int STBY_RETAIN_BIT = 0;

    // longest conversion time, rounded down to whole cycles
    localparam int CONV_TIME_NS = 10000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CONV = 2'h1,
        ST_HOLD = 2'h3
    } dacc_conv_state_t;
endpackage

/* core/dacc_chan_if.sv */
`timescale 1ns/1ns
interface dacc_chan_if #(parameter int DATA_W = 8);
    logic [DATA_W-1:0] code;
    logic code_wr;
    logic active;
    logic drive;
    logic [DATA_W-1:0] result;
    logic valid;
    logic active_q;
    logic drive_q;
    modport ctrl (output code, code_wr, active, drive, input result, valid, active_q, drive_q);
    modport chan (input code, code_wr, active, drive, output result, valid, active_q, drive_q);
endinterface

/* core/dacc_ahb_slave.sv */
`timescale 1ns/1ns
module dacc_ahb_slave (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // address phase
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    // decoded access
    output logic rd_req,
    output logic [31:0] rd_addr,
    output logic wr_pulse,
    output logic [31:0] wr_addr
);
    logic take;
    logic wr_pend;
    logic [31:0] wr_addr_q;
    logic next_wr_pend;
    logic [31:0] next_wr_addr;

    assign take = hsel && hready && (htrans == dacc_pkg::HTRANS_NONSEQ ||
                                     htrans == dacc_pkg::HTRANS_SEQ);
    assign rd_req = take && !hwrite;
    assign rd_addr = haddr;
    assign wr_pulse = wr_pend;
    assign wr_addr = wr_addr_q;

    always_comb begin
        next_wr_pend = take && hwrite;
        next_wr_addr = (take && hwrite) ? haddr : wr_addr_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr_q <= 32'h00000000;
        end else if (ce) begin
            wr_pend <= next_wr_pend;
            wr_addr_q <= next_wr_addr;
        end
    end
endmodule

/* core/dacc_channel.sv */
`timescale 1ns/1ns
module dacc_channel #(
    parameter int DATA_W = 8,
    parameter int CONV_CYCLES = dacc_pkg::CONV_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // control side
    dacc_chan_if.chan ch
);
    localparam int CNT_W = $clog2(CONV_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CONV_CYCLES - 1);

    if (CONV_CYCLES < 1) begin : g_bad_cycles
        $error("conversion cycle count must be at least one");
    end

    dacc_pkg::dacc_conv_state_t state, next_state;
    logic [CNT_W-1:0] count, next_count;
    logic [DATA_W-1:0] latched, next_latched;
    logic [DATA_W-1:0] result, next_result;
    logic valid, next_valid;
    logic active_q, next_active_q;
    logic drive_q, next_drive_q;

    assign ch.result = result;
    assign ch.valid = valid;
    assign ch.active_q = active_q;
    assign ch.drive_q = drive_q;

    always_comb begin
        next_state = state;
        next_count = count;
        next_latched = latched;
        next_result = result;
        next_valid = valid;
        next_active_q = ch.active;
        next_drive_q = ch.drive;
        if (!ch.active) begin
            next_state = dacc_pkg::ST_IDLE;
            next_valid = 1'b0;
            next_count = '0;
        end else if (state == dacc_pkg::ST_IDLE || ch.code_wr) begin
            // old result stays on the pin until the new one is ready
            next_state = dacc_pkg::ST_CONV;
            next_latched = ch.code;
            next_count = CNT_LOAD;
        end else if (state == dacc_pkg::ST_CONV) begin
            if (count == '0) begin
                next_state = dacc_pkg::ST_HOLD;
                next_result = latched;
                next_valid = 1'b1;
            end else begin
                next_count = count - 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= dacc_pkg::ST_IDLE;
            count <= '0;
            latched <= '0;
            result <= '0;
            valid <= 1'b0;
            active_q <= 1'b0;
            drive_q <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            count <= next_count;
            latched <= next_latched;
            result <= next_result;
            valid <= next_valid;
            active_q <= next_active_q;
            drive_q <= next_drive_q;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_CONV_DONE: assert property (
        (state == dacc_pkg::ST_CONV && count == '0 && ce && ch.active && !ch.code_wr)
        |=> (valid && result == $past(latched)))
        else $error("conversion end did not publish latched code");
    AST_RESULT_HOLD: assert property (
        (valid && state == dacc_pkg::ST_HOLD && ch.active && !ch.code_wr && ce)
        |=> $stable(result))
        else $error("held result changed without rewrite");
    AST_IDLE_NOVALID: assert property (
        (!ch.active && ce) |=> !valid)
        else $error("inactive channel still shows a valid result");
    COV_CONV_DONE: cover property ($rose(valid));
endmodule

/* core/dacc_top.sv */
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
module dacc_top #(
    parameter int CONV_CYCLES = dacc_pkg::CONV_CYCLES
) (
    // clock, reset, clock enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // power modes
    input wire logic hw_standby,
    input wire logic sw_standby,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // channel 0 analog side
    output logic [7:0] dac_code_ch0,
    output logic conv_active_ch0,
    output logic out_valid_ch0,
    output logic analog_out_pin0_oe,
    // channel 1 analog side
    output logic [7:0] dac_code_ch1,
    output logic conv_active_ch1,
    output logic out_valid_ch1,
    output logic analog_out_pin1_oe
);
    localparam int DW = dacc_pkg::DATA_W;

    // register state
    logic [DW-1:0] code_reg_ch0, next_code_reg_ch0;
    logic [DW-1:0] code_reg_ch1, next_code_reg_ch1;
    logic output_enable_ch0, next_output_enable_ch0;
    logic output_enable_ch1, next_output_enable_ch1;
    logic joint_conversion_enable, next_joint_conversion_enable;
    logic standby_retain_enable, next_standby_retain_enable;
    // bus answer state
    logic [31:0] next_hrdata;
    logic next_hreadyout;
    logic next_hresp;

    logic rd_req;
    logic [31:0] rd_addr;
    logic wr_pulse;
    logic [31:0] wr_addr;
    logic [DW-1:0] wdata;
    logic [7:0] converter_control_reg;
    logic [7:0] standby_control_reg;
    logic clear_regs;
    logic [dacc_pkg::NUM_CH-1:0] code_wr;
    logic [dacc_pkg::NUM_CH-1:0] oe_vec;
    logic [DW-1:0] code_vec [dacc_pkg::NUM_CH];

    dacc_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .rd_req(rd_req),
        .rd_addr(rd_addr),
        .wr_pulse(wr_pulse),
        .wr_addr(wr_addr)
    );

    // only word transfers are expected; size is not decoded
    assign wdata = hwdata[DW-1:0];

    // read views force reserved positions to one
    always_comb begin
        converter_control_reg = dacc_pkg::CTRL_RSVD_MASK;
        converter_control_reg[dacc_pkg::CTRL_OE1_BIT] = output_enable_ch1;
        converter_control_reg[dacc_pkg::CTRL_OE0_BIT] = output_enable_ch0;
        converter_control_reg[dacc_pkg::CTRL_JOINT_BIT] = joint_conversion_enable;
        standby_control_reg = dacc_pkg::STBY_RSVD_MASK;
        standby_control_reg[dacc_pkg::STBY_RETAIN_BIT] = standby_retain_enable;
    end

    // software standby without retain clears like a reset
    assign clear_regs = hw_standby || (sw_standby && !standby_retain_enable);

    always_comb begin
        next_code_reg_ch0 = code_reg_ch0;
        next_code_reg_ch1 = code_reg_ch1;
        next_output_enable_ch0 = output_enable_ch0;
        next_output_enable_ch1 = output_enable_ch1;
        next_joint_conversion_enable = joint_conversion_enable;
        next_standby_retain_enable = standby_retain_enable;
        code_wr = '0;
        if (clear_regs) begin
            next_code_reg_ch0 = dacc_pkg::CODE_RESET;
            next_code_reg_ch1 = dacc_pkg::CODE_RESET;
            next_output_enable_ch0 = dacc_pkg::CTRL_RESET[dacc_pkg::CTRL_OE0_BIT];
            next_output_enable_ch1 = dacc_pkg::CTRL_RESET[dacc_pkg::CTRL_OE1_BIT];
            next_joint_conversion_enable = dacc_pkg::CTRL_RESET[dacc_pkg::CTRL_JOINT_BIT];
            if (hw_standby) begin
                next_standby_retain_enable =
                    dacc_pkg::STBY_RESET[dacc_pkg::STBY_RETAIN_BIT];
            end
        end else if (sw_standby) begin
            // retained: cpu is halted, no register changes while asleep
            next_code_reg_ch0 = code_reg_ch0;
        end else if (wr_pulse) begin
            if (wr_addr == dacc_pkg::ADDR_CODE_CH0) begin
                next_code_reg_ch0 = wdata;
                code_wr[0] = 1'b1;
            end else if (wr_addr == dacc_pkg::ADDR_CODE_CH1) begin
                next_code_reg_ch1 = wdata;
                code_wr[1] = 1'b1;
            end else if (wr_addr == dacc_pkg::ADDR_CTRL) begin
                next_output_enable_ch1 = wdata[dacc_pkg::CTRL_OE1_BIT];
                next_output_enable_ch0 = wdata[dacc_pkg::CTRL_OE0_BIT];
                next_joint_conversion_enable = wdata[dacc_pkg::CTRL_JOINT_BIT];
            end else if (wr_addr == dacc_pkg::ADDR_STBY) begin
                next_standby_retain_enable = wdata[dacc_pkg::STBY_RETAIN_BIT];
            end
        end
    end

    // read data is latched in the address phase so hreadyout never drops
    always_comb begin
        next_hrdata = hrdata;
        next_hreadyout = 1'b1;
        next_hresp = dacc_pkg::HRESP_OKAY;
        if (rd_req) begin
            if (rd_addr == dacc_pkg::ADDR_CODE_CH0) begin
                next_hrdata = {24'h000000, code_reg_ch0};
            end else if (rd_addr == dacc_pkg::ADDR_CODE_CH1) begin
                next_hrdata = {24'h000000, code_reg_ch1};
            end else if (rd_addr == dacc_pkg::ADDR_CTRL) begin
                next_hrdata = {24'h000000, converter_control_reg};
            end else if (rd_addr == dacc_pkg::ADDR_STBY) begin
                next_hrdata = {24'h000000, standby_control_reg};
            end else begin
                next_hrdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            code_reg_ch0 <= dacc_pkg::CODE_RESET;
            code_reg_ch1 <= dacc_pkg::CODE_RESET;
            output_enable_ch0 <= dacc_pkg::CTRL_RESET[dacc_pkg::CTRL_OE0_BIT];
            output_enable_ch1 <= dacc_pkg::CTRL_RESET[dacc_pkg::CTRL_OE1_BIT];
            joint_conversion_enable <= dacc_pkg::CTRL_RESET[dacc_pkg::CTRL_JOINT_BIT];
            standby_retain_enable <= dacc_pkg::STBY_RESET[dacc_pkg::STBY_RETAIN_BIT];
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= dacc_pkg::HRESP_OKAY;
        end else if (ce) begin
            code_reg_ch0 <= next_code_reg_ch0;
            code_reg_ch1 <= next_code_reg_ch1;
            output_enable_ch0 <= next_output_enable_ch0;
            output_enable_ch1 <= next_output_enable_ch1;
            joint_conversion_enable <= next_joint_conversion_enable;
            standby_retain_enable <= next_standby_retain_enable;
            hrdata <= next_hrdata;
            hreadyout <= next_hreadyout;
            hresp <= next_hresp;
        end
    end

    assign oe_vec = {output_enable_ch1, output_enable_ch0};
    // channels see the value being written, so a rewrite converts the new code
    assign code_vec[0] = next_code_reg_ch0;
    assign code_vec[1] = next_code_reg_ch1;

    logic [DW-1:0] res_vec [dacc_pkg::NUM_CH];
    logic [dacc_pkg::NUM_CH-1:0] valid_vec;
    logic [dacc_pkg::NUM_CH-1:0] active_vec;
    logic [dacc_pkg::NUM_CH-1:0] drive_vec;

    for (genvar i = 0; i < dacc_pkg::NUM_CH; i++) begin : g_ch
        dacc_chan_if #(.DATA_W(DW)) ch_if ();
        assign ch_if.code = code_vec[i];
        assign ch_if.code_wr = code_wr[i];
        // the other channel's enable pulls this one in under joint mode
        assign ch_if.active = oe_vec[i] ||
                              (joint_conversion_enable && oe_vec[1-i]);
        assign ch_if.drive = oe_vec[i];
        dacc_channel #(.DATA_W(DW), .CONV_CYCLES(CONV_CYCLES)) u_chan (
            .hclk(hclk),
            .hresetn(hresetn),
            .ce(ce),
            .ch(ch_if.ctrl)
        );
        assign res_vec[i] = ch_if.result;
        assign valid_vec[i] = ch_if.valid;
        assign active_vec[i] = ch_if.active_q;
        assign drive_vec[i] = ch_if.drive_q;
    end

    // results go out continuously while the channel is converting
    assign dac_code_ch0 = res_vec[0];
    assign dac_code_ch1 = res_vec[1];
    assign out_valid_ch0 = valid_vec[0];
    assign out_valid_ch1 = valid_vec[1];
    assign conv_active_ch0 = active_vec[0];
    assign conv_active_ch1 = active_vec[1];
    assign analog_out_pin0_oe = drive_vec[0];
    assign analog_out_pin1_oe = drive_vec[1];

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_CODE_CLEAR: assert property (
        (hw_standby && ce) |=> (code_reg_ch0 == dacc_pkg::CODE_RESET &&
                                code_reg_ch1 == dacc_pkg::CODE_RESET))
        else $error("code registers not cleared in hardware standby");
    AST_RETAIN_KEEP: assert property (
        (sw_standby && !hw_standby && standby_retain_enable && ce)
        |=> ($stable(code_reg_ch0) && $stable(code_reg_ch1) &&
             $stable(converter_control_reg)))
        else $error("registers changed in retained software standby");
    AST_CTRL_CLEAR: assert property (
        (clear_regs && ce) |=> converter_control_reg == dacc_pkg::CTRL_RESET)
        else $error("control register not reinitialised on standby");
    AST_PIN1_DRIVE: assert property (
        ce |=> analog_out_pin1_oe == $past(output_enable_ch1))
        else $error("channel 1 pin drive does not follow its enable");
    AST_PIN0_DRIVE: assert property (
        ce |=> analog_out_pin0_oe == $past(output_enable_ch0))
        else $error("channel 0 pin drive does not follow its enable");
    AST_JOINT_ACTIVE: assert property (
        ce |=> (conv_active_ch0 == $past(output_enable_ch0 ||
                (joint_conversion_enable && output_enable_ch1)) &&
                conv_active_ch1 == $past(output_enable_ch1 ||
                (joint_conversion_enable && output_enable_ch0))))
        else $error("conversion activity does not match enables");
    AST_BOTH_OFF: assert property (
        (!output_enable_ch0 && !output_enable_ch1 && ce)
        |=> (!conv_active_ch0 && !conv_active_ch1))
        else $error("channel converts with both enables clear");
    AST_CTRL_RSVD: assert property (
        (converter_control_reg & dacc_pkg::CTRL_RSVD_MASK) == dacc_pkg::CTRL_RSVD_MASK)
        else $error("control reserved bits do not read one");
    AST_STBY_KEEP: assert property (
        (sw_standby && !hw_standby && ce) |=> $stable(standby_control_reg))
        else $error("standby register changed in software standby");
    AST_STBY_RSVD: assert property (
        (standby_control_reg & dacc_pkg::STBY_RSVD_MASK) == dacc_pkg::STBY_RSVD_MASK)
        else $error("standby reserved bits do not read one");
    AST_STBY_OFF: assert property (
        (sw_standby && !standby_retain_enable && ce) ##1 ce
        |=> (!analog_out_pin0_oe && !analog_out_pin1_oe))
        else $error("analog output still driven in software standby");
    AST_READ_ZERO_WAIT: assert property (
        hreadyout && hresp == dacc_pkg::HRESP_OKAY)
        else $error("slave inserted wait or error");
    // bus writes land one edge after the data phase unless a standby mode holds
    AST_CODE0_WRITE: assert property (
        (wr_pulse && wr_addr == dacc_pkg::ADDR_CODE_CH0 && !hw_standby && !sw_standby && ce)
        |=> code_reg_ch0 == $past(wdata))
        else $error("channel 0 code write did not land");
    AST_CODE1_WRITE: assert property (
        (wr_pulse && wr_addr == dacc_pkg::ADDR_CODE_CH1 && !hw_standby && !sw_standby && ce)
        |=> code_reg_ch1 == $past(wdata))
        else $error("channel 1 code write did not land");
    AST_CTRL_WRITE: assert property (
        (wr_pulse && wr_addr == dacc_pkg::ADDR_CTRL && !hw_standby && !sw_standby && ce)
        |=> converter_control_reg == ($past(wdata) | dacc_pkg::CTRL_RSVD_MASK))
        else $error("control write did not land as expected");
    AST_STBY_WRITE: assert property (
        (wr_pulse && wr_addr == dacc_pkg::ADDR_STBY && !hw_standby && !sw_standby && ce)
        |=> standby_control_reg == ($past(wdata) | dacc_pkg::STBY_RSVD_MASK))
        else $error("standby register write did not land as expected");

    // standby entry clears or keeps state; pin drive never follows joint mode
    AST_SW_CODE_CLEAR: assert property (
        (sw_standby && !standby_retain_enable && ce)
        |=> (code_reg_ch0 == dacc_pkg::CODE_RESET && code_reg_ch1 == dacc_pkg::CODE_RESET))
        else $error("code registers not cleared in software standby");
    AST_STBY_HW_RESET: assert property (
        (hw_standby && ce) |=> standby_control_reg == dacc_pkg::STBY_RESET)
        else $error("standby register not reinitialised in hardware standby");
    AST_HW_PIN_OFF: assert property (
        (hw_standby && ce) ##1 ce |=> (!analog_out_pin0_oe && !analog_out_pin1_oe))
        else $error("analog pin still driven in hardware standby");
    AST_JOINT_PIN0: assert property (
        (joint_conversion_enable && !output_enable_ch0 && ce) |=> !analog_out_pin0_oe)
        else $error("joint mode drove channel 0 pin without its enable");
    AST_JOINT_PIN1: assert property (
        (joint_conversion_enable && !output_enable_ch1 && ce) |=> !analog_out_pin1_oe)
        else $error("joint mode drove channel 1 pin without its enable");
    AST_READ_HIGH_ZERO: assert property (
        hrdata[31:DW] == '0)
        else $error("read data carries bits above the register");

    COV_JOINT: cover property (joint_conversion_enable && output_enable_ch0 &&
                               !output_enable_ch1 ##1 conv_active_ch1);
    COV_RETAIN: cover property (sw_standby && standby_retain_enable && analog_out_pin0_oe);
    COV_REWRITE: cover property (out_valid_ch0 && code_wr[0]);
    COV_HW_CLEAR: cover property (hw_standby && out_valid_ch0);
endmodule

/* tb/dacc_analog_model.sv */
`timescale 1ns/1ns
module dacc_analog_model (
    // clock
    input wire logic hclk,
    // converter control side
    input wire logic [7:0] code,
    input wire logic valid,
    input wire logic oe,
    // pin level seen on the board
    output logic [7:0] pin_level
);
    logic [7:0] float_pat = 8'h96;

    // a released pin floats; toggling keeps a stale code from passing as driven
    always @(posedge hclk) begin
        float_pat <= ~float_pat;
    end

    always_comb begin
        if (oe && valid) begin
            pin_level = code;
        end else begin
            pin_level = float_pat;
        end
    end
endmodule

/* tb/dacc_top_bench.sv */
`timescale 1ns/1ns
module dacc_top_bench;
    localparam int CONV = 4;
    localparam logic [31:0] A_C0 = dacc_pkg::ADDR_CODE_CH0;
    localparam logic [31:0] A_C1 = dacc_pkg::ADDR_CODE_CH1;
    localparam logic [31:0] A_CT = dacc_pkg::ADDR_CTRL;
    localparam logic [31:0] A_SB = dacc_pkg::ADDR_STBY;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hw_standby = 1'b0;
    logic sw_standby = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [7:0] code0;
    logic [7:0] code1;
    logic [7:0] pin0;
    logic [7:0] pin1;
    logic act0, act1, val0, val1, oe0, oe1;
    logic [31:0] rd;
    logic [2:0] sel;
    int mismatches = 0;
    int checked = 0;

    always #4 hclk = ~hclk;

    dacc_top #(.CONV_CYCLES(CONV)) dacc_top_i (
        .hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hw_standby(hw_standby), .sw_standby(sw_standby),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .dac_code_ch0(code0), .conv_active_ch0(act0), .out_valid_ch0(val0),
        .analog_out_pin0_oe(oe0),
        .dac_code_ch1(code1), .conv_active_ch1(act1), .out_valid_ch1(val1),
        .analog_out_pin1_oe(oe1)
    );
    dacc_analog_model dacc_analog_model_i0 (
        .hclk(hclk), .code(code0), .valid(val0), .oe(oe0), .pin_level(pin0)
    );
    dacc_analog_model dacc_analog_model_i1 (
        .hclk(hclk), .code(code1), .valid(val1), .oe(oe1), .pin_level(pin1)
    );

    task automatic report_and_stop();
        if (mismatches == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one edge, then more until hready is seen high
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                mismatches++;
                report_and_stop();
            end
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= dacc_pkg::HTRANS_NONSEQ;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        chk({31'h0, hresp}, {31'h0, dacc_pkg::HRESP_OKAY});
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic wait_valid0();
        int n;
        n = 0;
        while (val0 !== 1'b1) begin
            settle(1);
            n++;
            if (n > CONV + 20) begin
                mismatches++;
                report_and_stop();
            end
        end
    endtask

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(A_C0, 32'h00000000);
        rdchk(A_C1, 32'h00000000);
        rdchk(A_CT, 32'h0000001F);
        rdchk(A_SB, 32'h000000FE);
        rdchk(32'h00000100, 32'h00000000);
        wr(A_CT, 32'h00000000);
        rdchk(A_CT, 32'h0000001F);
        wr(A_SB, 32'h00000000);
        rdchk(A_SB, 32'h000000FE);
        wr(A_C0, 32'h000000A5);
        wr(A_C1, 32'h0000003C);
        rdchk(A_C0, 32'h000000A5);
        rdchk(A_C1, 32'h0000003C);
        wr(A_CT, 32'h00000040);
        wait_valid0();
        chk({24'h0, code0}, 32'h000000A5);
        chk({24'h0, pin0}, 32'h000000A5);
        // rewrite: old result stands until the new one is converted
        wr(A_C0, 32'h0000005A);
        #1;
        chk({24'h0, code0}, 32'h000000A5);
        settle(CONV + 2);
        chk({24'h0, code0}, 32'h0000005A);
        chk({24'h0, pin0}, 32'h0000005A);
        // every combination; long enough for a fresh conversion to finish
        for (int i = 0; i < 8; i++) begin
            sel = i[2:0];
            wr(A_CT, {24'h0, sel, 5'h00});
            settle(CONV + 3);
            chk({act0, oe0, act1, oe1}, {28'h0, sel[1] | (sel[0] & sel[2]), sel[1],
                sel[2] | (sel[0] & sel[1]), sel[2]});
            chk({30'h0, val0, val1}, {30'h0, sel[1] | (sel[0] & sel[2]),
                sel[2] | (sel[0] & sel[1])});
        end
        chk({24'h0, code1}, 32'h0000003C);
        chk({24'h0, pin1}, 32'h0000003C);
        wr(A_CT, 32'h00000040);
        @(posedge hclk);
        sw_standby <= 1'b1;
        settle(3);
        chk({31'h0, oe0}, 32'h00000000);
        @(posedge hclk);
        sw_standby <= 1'b0;
        rdchk(A_C0, 32'h00000000);
        rdchk(A_CT, 32'h0000001F);
        wr(A_SB, 32'h00000001);
        rdchk(A_SB, 32'h000000FF);
        wr(A_C0, 32'h000000C3);
        wr(A_CT, 32'h00000040);
        @(posedge hclk);
        sw_standby <= 1'b1;
        settle(CONV + 3);
        chk({30'h0, oe0, val0}, 32'h00000003);
        chk({24'h0, pin0}, 32'h000000C3);
        @(posedge hclk);
        sw_standby <= 1'b0;
        rdchk(A_C0, 32'h000000C3);
        rdchk(A_CT, 32'h0000005F);
        rdchk(A_SB, 32'h000000FF);
        @(posedge hclk);
        hw_standby <= 1'b1;
        settle(3);
        chk({31'h0, oe0}, 32'h00000000);
        @(posedge hclk);
        hw_standby <= 1'b0;
        rdchk(A_SB, 32'h000000FE);
        rdchk(A_C0, 32'h00000000);
        rdchk(A_CT, 32'h0000001F);
        report_and_stop();
    end
endmodule
